// [common/pefm_cfg.svh]
// pin map, reset values and widths for the port e/f override block
`ifndef PEFM_CFG_SVH
`define PEFM_CFG_SVH

// port e pin positions
`define PEFM_PE_RX       0
`define PEFM_PE_TX       1
`define PEFM_PE_UCLK     2
`define PEFM_PE_CMPN     3
`define PEFM_PE_SCL      4
`define PEFM_PE_SDA      5
`define PEFM_PE_SDO      6
`define PEFM_PE_CKO      7

// port f test port pin positions
`define PEFM_PF_TCK      4
`define PEFM_PF_TMS      5
`define PEFM_PF_TDO      6
`define PEFM_PF_TDI      7

// pins per port
`define PEFM_PORT_W      8

// port f pull-ups held on through reset (test port pins)
`define PEFM_PF_PU_RST   8'hf0

// test port register widths
`define PEFM_IR_W        4
`define PEFM_DR_W        8

`endif

// [common/pefm_pkg.sv]
// types shared by the port e/f override block
package pefm_pkg;

    // one pin's set of override controls
    typedef struct packed {
        logic pullup_ovr_en;
        logic pullup_ovr_val;
        logic dir_ovr_en;
        logic dir_ovr_val;
        logic value_ovr_en;
        logic value_ovr_val;
        logic inbuf_ovr_en;
        logic inbuf_ovr_val;
    } pefm_ovr_t;

    // resolved drive of one 8-pin port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pu;
        logic [7:0] die;
    } pefm_drive_t;

    typedef enum logic [3:0] {
        TAP_RESET,
        TAP_IDLE,
        TAP_SEL_DR,
        TAP_CAP_DR,
        TAP_SHIFT_DR,
        TAP_EXIT1_DR,
        TAP_PAUSE_DR,
        TAP_EXIT2_DR,
        TAP_UPD_DR,
        TAP_SEL_IR,
        TAP_CAP_IR,
        TAP_SHIFT_IR,
        TAP_EXIT1_IR,
        TAP_PAUSE_IR,
        TAP_EXIT2_IR,
        TAP_UPD_IR
    } pefm_tap_t;

endpackage

// [logic/pefm_pin_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module pefm_pin_sync
#(
    parameter int W = 16
)
(
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] pin_i,
    output var  logic [W-1:0] level_o
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end
        else
        begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a change counts once stages two and three agree
    for (genvar i = 0; i < W; i++)
    begin : g_filt
        always_ff @(posedge clk_i or negedge rst_n_i)
        begin
            if (!rst_n_i)
                level_o[i] <= 1'b0;
            else if (s2[i] == s3[i])
                level_o[i] <= s3[i];
        end
    end

endmodule // pefm_pin_sync

`default_nettype wire

// [logic/pefm_mux.sv]
// pin override mux for ports e and f with test access port
`timescale 1ns/1ps
`default_nettype none
`include "pefm_cfg.svh"

// How it works
// - receiver on forces pin e0 to input
// - receiver on: pin e0 pull-up follows latch and global pull-up control
// - two-wire: pin e5 pull-up off, open-drain drive of zero
// - two-wire: pin e4 direction from hold, latch, dir; drives zero; toggle strobe reaches the pin only outside two-wire
// - clock-output fuse forces pin e7 out driving the i/o clock
// - pin-change mask plus group enable force input buffer on
// - pins e3/e2 buffer off on comparator disable unless pin change on
// - test port pull-ups on port f loaded on by reset, then held on only while test port enabled
// - test port enabled removes port f bits 7..4 from general use
// - test data out drives only in shift states, else pulled high
// - test port state machine advances only on test clock rising edges; forced to reset while test port disabled
// - test data in shifts into instruction or selected data register
// - port f pins are analog channels; bits 7..4 carry test port pins

module pefm_mux
    import pefm_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] pe_latch_i,
    input  wire logic [7:0] pe_dir_i,
    input  wire logic [7:0] pe_pin_i,
    input  wire logic [7:0] pf_latch_i,
    input  wire logic [7:0] pf_dir_i,
    input  wire logic [7:0] pf_pin_i,
    input  wire logic       pullup_global_off_i,
    input  wire logic       receiver_on_i,
    input  wire logic       transmitter_on_i,
    input  wire logic       tx_data_i,
    input  wire logic       usart_ext_clock_oe_i,
    input  wire logic       usart_ext_clock_i,
    input  wire logic       two_wire_mode_sel_i,
    input  wire logic       three_wire_mode_sel_i,
    input  wire logic       clock_stretch_hold_i,
    input  wire logic       serial_clock_toggle_strobe_i,
    input  wire logic       start_detect_irq_on_i,
    input  wire logic       serial_data_out_i,
    input  wire logic       clock_output_fuse_i,
    input  wire logic       io_clock_i,
    input  wire logic [7:0] pin_change_mask_i,
    input  wire logic       pin_change_group_on_i,
    input  wire logic       comp_pos_input_off_i,
    input  wire logic       comp_neg_input_off_i,
    input  wire logic       jtag_enable_i,
    input  wire logic [7:0] dr_capture_i,
    output logic      [7:0] pe_out_o,
    output logic      [7:0] pe_oe_o,
    output logic      [7:0] pe_pullup_o,
    output logic      [7:0] pe_in_o,
    output logic      [7:0] pf_out_o,
    output logic      [7:0] pf_oe_o,
    output logic      [7:0] pf_pullup_o,
    output logic      [7:0] pf_in_o,
    output logic            rx_data_o,
    output logic            usart_ext_clock_in_o,
    output logic            serial_data_in_o,
    output logic            serial_clk_pin_o,
    output logic      [7:0] pin_change_src_o,
    output logic      [3:0] tap_ir_o,
    output logic      [7:0] dr_update_o
);

    localparam int IRW = `PEFM_IR_W;
    localparam int DRW = `PEFM_DR_W;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [15:0] pins;

    pefm_pin_sync #(.W(16)) u_sync
    (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   ({pf_pin_i, pe_pin_i}),
        .level_o (pins)
    );

    // ------------------------------------------------------------
    // test access port
    // ------------------------------------------------------------
    pefm_tap_t      tap_state;
    pefm_tap_t      next_tap;
    logic           tck_prev;
    logic           tck_rise;
    logic           tms;
    logic           tdi;
    logic [IRW-1:0] ir_sr;
    logic [DRW-1:0] dr_sr;
    logic           byp;
    logic           sel_byp;
    logic           shifting;
    logic           tdo;

    // test port rides on port f bits 7..4
    assign tms      = pins[8 + `PEFM_PF_TMS];
    assign tdi      = pins[8 + `PEFM_PF_TDI];
    assign tck_rise = jtag_enable_i && pins[8 + `PEFM_PF_TCK] && !tck_prev;
    assign sel_byp  = &tap_ir_o;
    assign shifting = (tap_state == TAP_SHIFT_IR) ||
                      (tap_state == TAP_SHIFT_DR);
    assign tdo      = (tap_state == TAP_SHIFT_IR) ? ir_sr[0] :
                      (sel_byp ? byp : dr_sr[0]);

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tck_prev <= 1'b0;
        else
            tck_prev <= pins[8 + `PEFM_PF_TCK];
    end

    always_comb
    begin
        case (tap_state)
            TAP_RESET:    next_tap = tms ? TAP_RESET   : TAP_IDLE;
            TAP_IDLE:     next_tap = tms ? TAP_SEL_DR  : TAP_IDLE;
            TAP_SEL_DR:   next_tap = tms ? TAP_SEL_IR  : TAP_CAP_DR;
            TAP_CAP_DR:   next_tap = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: next_tap = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: next_tap = tms ? TAP_UPD_DR  : TAP_PAUSE_DR;
            TAP_PAUSE_DR: next_tap = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: next_tap = tms ? TAP_UPD_DR  : TAP_SHIFT_DR;
            TAP_UPD_DR:   next_tap = tms ? TAP_SEL_DR  : TAP_IDLE;
            TAP_SEL_IR:   next_tap = tms ? TAP_RESET   : TAP_CAP_IR;
            TAP_CAP_IR:   next_tap = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: next_tap = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: next_tap = tms ? TAP_UPD_IR  : TAP_PAUSE_IR;
            TAP_PAUSE_IR: next_tap = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: next_tap = tms ? TAP_UPD_IR  : TAP_SHIFT_IR;
            TAP_UPD_IR:   next_tap = tms ? TAP_SEL_DR  : TAP_IDLE;
            default:      next_tap = TAP_RESET;
        endcase
    end

    // state forced to reset while test port disabled, else advances on test clock rising edges
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tap_state <= TAP_RESET;
        else if (!jtag_enable_i)
            tap_state <= TAP_RESET;
        else if (tck_rise)
            tap_state <= next_tap;
    end

    // instruction path
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ir_sr    <= '0;
            tap_ir_o <= '1;
        end
        else if (tap_state == TAP_RESET)
            tap_ir_o <= '1;
        else if (tck_rise)
        begin
            case (tap_state)
                TAP_CAP_IR:   ir_sr    <= IRW'(1);
                TAP_SHIFT_IR: ir_sr    <= {tdi, ir_sr[IRW-1:1]};
                TAP_UPD_IR:   tap_ir_o <= ir_sr;
                default:      ir_sr    <= ir_sr;
            endcase
        end
    end

    // data path: bypass bit or data chain chosen by instruction
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dr_sr       <= '0;
            byp         <= 1'b0;
            dr_update_o <= '0;
        end
        else if (tck_rise)
        begin
            case (tap_state)
                TAP_CAP_DR:
                begin
                    dr_sr <= dr_capture_i;
                    byp   <= 1'b0;
                end
                TAP_SHIFT_DR:
                begin
                    if (sel_byp)
                        byp <= tdi;
                    else
                        dr_sr <= {tdi, dr_sr[DRW-1:1]};
                end
                TAP_UPD_DR:
                begin
                    if (!sel_byp)
                        dr_update_o <= dr_sr;
                end
                default:
                begin
                    byp <= byp;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // override tables
    // ------------------------------------------------------------
    pefm_ovr_t ovr_e [8];
    pefm_ovr_t ovr_f [8];
    logic [7:0] pc_on;
    logic       pu_off;
    logic       tgl_scl;

    assign pc_on  = pin_change_mask_i & {8{pin_change_group_on_i}};
    assign pu_off = pullup_global_off_i;

    always_comb
    begin
        for (int k = 0; k < 8; k++)
        begin
            ovr_e[k]               = '0;
            ovr_f[k]               = '0;
            ovr_e[k].inbuf_ovr_en  = pc_on[k];
            ovr_e[k].inbuf_ovr_val = 1'b1;
        end
        // receive pin
        ovr_e[`PEFM_PE_RX].dir_ovr_en = receiver_on_i;
        ovr_e[`PEFM_PE_RX].dir_ovr_val = 1'b0;
        ovr_e[`PEFM_PE_RX].pullup_ovr_en = receiver_on_i;
        ovr_e[`PEFM_PE_RX].pullup_ovr_val = pe_latch_i[0] & ~pu_off;
        // transmit pin
        ovr_e[`PEFM_PE_TX].pullup_ovr_en = transmitter_on_i;
        ovr_e[`PEFM_PE_TX].dir_ovr_en = transmitter_on_i;
        ovr_e[`PEFM_PE_TX].dir_ovr_val = 1'b1;
        ovr_e[`PEFM_PE_TX].value_ovr_en = transmitter_on_i;
        ovr_e[`PEFM_PE_TX].value_ovr_val = tx_data_i;
        // usart clock / comparator positive
        ovr_e[`PEFM_PE_UCLK].value_ovr_en = usart_ext_clock_oe_i;
        ovr_e[`PEFM_PE_UCLK].value_ovr_val = usart_ext_clock_i;
        ovr_e[`PEFM_PE_UCLK].inbuf_ovr_en =
            pc_on[2] | comp_pos_input_off_i;
        ovr_e[`PEFM_PE_UCLK].inbuf_ovr_val = pc_on[2];
        // comparator negative
        ovr_e[`PEFM_PE_CMPN].inbuf_ovr_en =
            pc_on[3] | comp_neg_input_off_i;
        ovr_e[`PEFM_PE_CMPN].inbuf_ovr_val = pc_on[3];
        // serial clock
        ovr_e[`PEFM_PE_SCL].dir_ovr_en = two_wire_mode_sel_i;
        ovr_e[`PEFM_PE_SCL].dir_ovr_val =
            (clock_stretch_hold_i | pe_latch_i[4]) & pe_dir_i[4];
        ovr_e[`PEFM_PE_SCL].value_ovr_en =
            two_wire_mode_sel_i & pe_dir_i[4];
        ovr_e[`PEFM_PE_SCL].inbuf_ovr_en =
            pc_on[4] | start_detect_irq_on_i;
        // serial data
        ovr_e[`PEFM_PE_SDA].pullup_ovr_en = two_wire_mode_sel_i;
        ovr_e[`PEFM_PE_SDA].dir_ovr_en = two_wire_mode_sel_i;
        ovr_e[`PEFM_PE_SDA].dir_ovr_val =
            (pins[5] | pe_latch_i[5]) & pe_dir_i[5];
        ovr_e[`PEFM_PE_SDA].value_ovr_en =
            two_wire_mode_sel_i & pe_dir_i[5];
        ovr_e[`PEFM_PE_SDA].inbuf_ovr_en =
            pc_on[5] | start_detect_irq_on_i;
        // serial data output
        ovr_e[`PEFM_PE_SDO].value_ovr_en = three_wire_mode_sel_i;
        ovr_e[`PEFM_PE_SDO].value_ovr_val = serial_data_out_i;
        // clock output
        ovr_e[`PEFM_PE_CKO].dir_ovr_en = clock_output_fuse_i;
        ovr_e[`PEFM_PE_CKO].dir_ovr_val = 1'b1;
        ovr_e[`PEFM_PE_CKO].value_ovr_en = clock_output_fuse_i;
        ovr_e[`PEFM_PE_CKO].value_ovr_val = io_clock_i;
        // port f test port pins
        for (int k = 4; k < 8; k++)
        begin
            ovr_f[k].pullup_ovr_en  = jtag_enable_i;
            ovr_f[k].pullup_ovr_val = 1'b1;
            ovr_f[k].dir_ovr_en     = jtag_enable_i;
            ovr_f[k].value_ovr_en   = jtag_enable_i;
            ovr_f[k].inbuf_ovr_en   = jtag_enable_i;
        end
        ovr_f[`PEFM_PF_TDO].dir_ovr_val = shifting;
        ovr_f[`PEFM_PF_TDO].value_ovr_val = tdo;
    end

    // serial clock toggle strobe flips the pin value
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tgl_scl <= 1'b0;
        else if (serial_clock_toggle_strobe_i)
            tgl_scl <= ~tgl_scl;
    end

    // ------------------------------------------------------------
    // per-pin resolution
    // ------------------------------------------------------------
    pefm_drive_t next_e;
    pefm_drive_t next_f;
    logic [7:0]  tgl_e;

    assign tgl_e = {3'h0, tgl_scl, 4'h0};

    for (genvar i = 0; i < 8; i++)
    begin : g_pin
        assign next_e.oe[i]  = ovr_e[i].dir_ovr_en ? ovr_e[i].dir_ovr_val
                             : pe_dir_i[i];
        assign next_e.out[i] = ovr_e[i].value_ovr_en ? ovr_e[i].value_ovr_val
                             : pe_latch_i[i] ^ tgl_e[i];
        assign next_e.pu[i]  = ovr_e[i].pullup_ovr_en ? ovr_e[i].pullup_ovr_val
                             : pe_latch_i[i] & ~pe_dir_i[i] & ~pu_off;
        assign next_e.die[i] = ovr_e[i].inbuf_ovr_en ? ovr_e[i].inbuf_ovr_val
                             : 1'b1;
        assign next_f.oe[i]  = ovr_f[i].dir_ovr_en ? ovr_f[i].dir_ovr_val
                             : pf_dir_i[i];
        assign next_f.out[i] = ovr_f[i].value_ovr_en ? ovr_f[i].value_ovr_val
                             : pf_latch_i[i];
        assign next_f.pu[i]  = ovr_f[i].pullup_ovr_en ? ovr_f[i].pullup_ovr_val
                             : pf_latch_i[i] & ~pf_dir_i[i] & ~pu_off;
        assign next_f.die[i] = ovr_f[i].inbuf_ovr_en ? ovr_f[i].inbuf_ovr_val
                             : 1'b1;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pe_out_o    <= '0;
            pe_oe_o     <= '0;
            pe_pullup_o <= '0;
            pf_out_o    <= '0;
            pf_oe_o     <= '0;
            pf_pullup_o <= `PEFM_PF_PU_RST;
        end
        else
        begin
            pe_out_o    <= next_e.out;
            pe_oe_o     <= next_e.oe;
            pe_pullup_o <= next_e.pu;
            pf_out_o    <= next_f.out;
            pf_oe_o     <= next_f.oe;
            pf_pullup_o <= next_f.pu;
        end
    end

    // inputs to peripherals and pin registers
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pe_in_o              <= '0;
            pf_in_o              <= '0;
            rx_data_o            <= 1'b0;
            usart_ext_clock_in_o <= 1'b0;
            serial_data_in_o     <= 1'b0;
            serial_clk_pin_o     <= 1'b0;
            pin_change_src_o     <= '0;
        end
        else
        begin
            pe_in_o              <= pins[7:0] & next_e.die;
            pf_in_o              <= pins[15:8] & next_f.die;
            rx_data_o            <= pins[0] & next_e.die[0];
            usart_ext_clock_in_o <= pins[2] & next_e.die[2];
            serial_data_in_o     <= pins[5] & next_e.die[5];
            serial_clk_pin_o     <= pins[4] & next_e.die[4];
            pin_change_src_o     <= pins[7:0] & next_e.die & pc_on;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_ir_shift_edge;
        tck_rise && tap_state == TAP_SHIFT_IR;
    endsequence

    a_rx_input_dir: assert property (receiver_on_i |=> !pe_oe_o[0])
        else $error("receive pin not forced to input");
    a_rx_pullup: assert property ((receiver_on_i && pe_latch_i[0] && !pu_off)
        |=> pe_pullup_o[0])
        else $error("receive pin pull-up not on");
    a_sda_open_drain: assert property (two_wire_mode_sel_i |=>
        !pe_pullup_o[5] && (!$past(pe_dir_i[5]) || !pe_out_o[5]))
        else $error("data pin not open drain in two-wire mode");
    a_scl_dir_hold: assert property ((two_wire_mode_sel_i && pe_dir_i[4]
        && clock_stretch_hold_i) |=> pe_oe_o[4] && !pe_out_o[4])
        else $error("clock pin not held low");
    a_clk_out_pin: assert property (clock_output_fuse_i |=> pe_oe_o[7]
        && pe_out_o[7] == $past(io_clock_i))
        else $error("clock output pin wrong");
    a_pc_inbuf_on: assert property (pc_on[6] |-> next_e.die[6])
        else $error("pin change buffer not enabled");
    a_cmp_inbuf_off: assert property ((comp_neg_input_off_i && !pc_on[3])
        |-> !next_e.die[3])
        else $error("comparator pin buffer still on");
    a_start_inbuf_on: assert property (start_detect_irq_on_i
        |-> next_e.die[5] && next_e.die[4])
        else $error("serial pin buffers off");
    a_jtag_pullups: assert property (jtag_enable_i |=> pf_pullup_o[7]
        && pf_pullup_o[5] && pf_pullup_o[4])
        else $error("test port pull-up dropped");
    a_jtag_gpio_off: assert property (jtag_enable_i |=>
        pf_oe_o[7:4] == {1'b0, $past(shifting), 2'b00} &&
        (pf_out_o & 8'hb0) == 8'h00)
        else $error("test port pin under port control");
    a_tdo_drive: assert property ((jtag_enable_i && !shifting)
        |=> !pf_oe_o[6] && pf_pullup_o[6])
        else $error("test data out driven outside shift");
    a_tap_on_tck: assert property ($changed(tap_state) |->
        $past(tck_rise) || !$past(jtag_enable_i))
        else $error("tap state moved without test clock");
    a_ir_shift_in: assert property (s_ir_shift_edge |=>
        ir_sr[IRW-1] == $past(tdi))
        else $error("instruction bit not shifted in");
    a_tx_pin: assert property (transmitter_on_i |=> pe_oe_o[1]
        && !pe_pullup_o[1] && pe_out_o[1] == $past(tx_data_i))
        else $error("transmit pin wrong");
    a_sdo_value: assert property (three_wire_mode_sel_i |=>
        pe_out_o[6] == $past(serial_data_out_i))
        else $error("serial data output not on pin");

endmodule // pefm_mux

`default_nettype wire

// [bench/pefm_pad_model.sv]
// pad model: resolves each pin level from all parties driving it
`timescale 1ns/1ps
`default_nettype none
module pefm_pad_model
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] out_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] pu_i,
    input  wire logic [7:0] ext_oe_i,
    input  wire logic [7:0] ext_i,
    output var  logic [7:0] pin_o
);
    logic [7:0] last;
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            last <= 8'h00;
        else
            last <= pin_o;
    end
    // a released pin without pull-up drifts off its last level
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (oe_i[i])
                pin_o[i] = out_i[i];
            else if (ext_oe_i[i])
                pin_o[i] = ext_i[i];
            else
                pin_o[i] = pu_i[i] | ~last[i];
        end
    end
endmodule // pefm_pad_model
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench for the port e/f override mux
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       clk_i, rst_n_i, pullup_global_off_i, receiver_on_i;
    logic       transmitter_on_i, tx_data_i, usart_ext_clock_oe_i;
    logic       usart_ext_clock_i, two_wire_mode_sel_i, io_clock_i;
    logic       three_wire_mode_sel_i, clock_stretch_hold_i;
    logic       serial_clock_toggle_strobe_i, start_detect_irq_on_i;
    logic       serial_data_out_i, clock_output_fuse_i, jtag_enable_i;
    logic       pin_change_group_on_i, comp_pos_input_off_i;
    logic       comp_neg_input_off_i, rx_data_o, usart_ext_clock_in_o;
    logic       serial_data_in_o, serial_clk_pin_o;
    logic [3:0] tap_ir_o;
    logic [7:0] pe_latch_i, pe_dir_i, pe_pin_i, pf_latch_i, pf_dir_i;
    logic [7:0] pf_pin_i, pin_change_mask_i, dr_capture_i, pe_out_o;
    logic [7:0] pe_oe_o, pe_pullup_o, pe_in_o, pf_out_o, pf_oe_o;
    logic [7:0] pf_pullup_o, pf_in_o, pin_change_src_o, dr_update_o;
    logic [7:0] pf_ext, scan_word;
    int         n_errors, total_checks;

    pefm_mux dut_u
    (
        .clk_i, .rst_n_i, .pe_latch_i, .pe_dir_i, .pe_pin_i, .pf_latch_i,
        .pf_dir_i, .pf_pin_i, .pullup_global_off_i, .receiver_on_i,
        .transmitter_on_i, .tx_data_i, .usart_ext_clock_oe_i,
        .usart_ext_clock_i, .two_wire_mode_sel_i, .three_wire_mode_sel_i,
        .clock_stretch_hold_i, .serial_clock_toggle_strobe_i,
        .start_detect_irq_on_i, .serial_data_out_i, .clock_output_fuse_i,
        .io_clock_i, .pin_change_mask_i, .pin_change_group_on_i,
        .comp_pos_input_off_i, .comp_neg_input_off_i, .jtag_enable_i,
        .dr_capture_i, .pe_out_o, .pe_oe_o, .pe_pullup_o, .pe_in_o,
        .pf_out_o, .pf_oe_o, .pf_pullup_o, .pf_in_o, .rx_data_o,
        .usart_ext_clock_in_o, .serial_data_in_o, .serial_clk_pin_o,
        .pin_change_src_o, .tap_ir_o, .dr_update_o
    );
    pefm_pad_model pe_pad_u
    (
        .clk_i, .rst_n_i, .out_i(pe_out_o), .oe_i(pe_oe_o),
        .pu_i(pe_pullup_o), .ext_oe_i(8'hff), .ext_i(8'hff), .pin_o(pe_pin_i)
    );
    // test data out left to the pad and its pull-up
    pefm_pad_model pf_pad_u
    (
        .clk_i, .rst_n_i, .out_i(pf_out_o), .oe_i(pf_oe_o),
        .pu_i(pf_pullup_o), .ext_oe_i(8'hbf), .ext_i(pf_ext), .pin_o(pf_pin_i)
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // one test clock period, mode select and data set while clock low
    task automatic tck(input logic tms, input logic tdi);
        pf_ext = {tdi, 1'b0, tms, 5'h00};
        step(8);
        pf_ext[4] = 1'b1;
        step(8);
    endtask
    task automatic summarize;
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial
    begin
        #200000;
        n_errors++;
        summarize;
    end
    initial
    begin
        {pullup_global_off_i, receiver_on_i, transmitter_on_i, tx_data_i,
         usart_ext_clock_oe_i, usart_ext_clock_i, two_wire_mode_sel_i,
         three_wire_mode_sel_i, clock_stretch_hold_i, io_clock_i,
         serial_clock_toggle_strobe_i, start_detect_irq_on_i,
         serial_data_out_i, clock_output_fuse_i, pin_change_group_on_i,
         comp_pos_input_off_i, comp_neg_input_off_i, jtag_enable_i,
         pe_latch_i, pe_dir_i, pf_latch_i, pf_dir_i, pin_change_mask_i,
         dr_capture_i, pf_ext} = '0;
        n_errors = 0;
        total_checks = 0;
        rst_n_i = 1'b0;
        step(8);
        chk(pf_pullup_o, 8'hf0);
        chk({4'h0, tap_ir_o}, 8'h0f);
        rst_n_i = 1'b1;
        pe_dir_i = 8'h01;
        pe_latch_i = 8'h03;
        receiver_on_i = 1'b1;
        transmitter_on_i = 1'b1;
        tx_data_i = 1'b1;
        step(2);
        chk(pe_oe_o & 8'h03, 8'h02);
        chk(pe_out_o & 8'h02, 8'h02);
        chk(pe_pullup_o & 8'h03, 8'h01);
        pullup_global_off_i = 1'b1;
        step(2);
        chk(pe_pullup_o & 8'h01, 8'h00);
        clock_output_fuse_i = 1'b1;
        io_clock_i = 1'b1;
        step(2);
        chk(pe_oe_o & 8'h80, 8'h80);
        chk(pe_out_o & 8'h80, 8'h80);
        io_clock_i = 1'b0;
        step(2);
        chk(pe_out_o & 8'h80, 8'h00);
        pe_dir_i = 8'h71;
        pe_latch_i = 8'h33;
        two_wire_mode_sel_i = 1'b1;
        clock_stretch_hold_i = 1'b1;
        step(2);
        chk(pe_out_o & 8'h30, 8'h00);
        chk(pe_oe_o & 8'h30, 8'h30);
        chk(pe_pullup_o & 8'h20, 8'h00);
        two_wire_mode_sel_i = 1'b0;
        three_wire_mode_sel_i = 1'b1;
        serial_data_out_i = 1'b1;
        step(2);
        chk(pe_out_o & 8'h40, 8'h40);
        serial_clock_toggle_strobe_i = 1'b1;
        start_detect_irq_on_i = 1'b1;
        step(1);
        serial_clock_toggle_strobe_i = 1'b0;
        step(1);
        chk(pe_out_o & 8'h10, 8'h00);
        comp_pos_input_off_i = 1'b1;
        comp_neg_input_off_i = 1'b1;
        step(8);
        chk(pe_in_o & 8'h0c, 8'h00);
        pin_change_mask_i = 8'h4c;
        pin_change_group_on_i = 1'b1;
        step(8);
        chk(pe_in_o & 8'h0c, 8'h0c);
        chk(pin_change_src_o & 8'h4c, 8'h4c);
        chk({4'h0, rx_data_o, usart_ext_clock_in_o, serial_clk_pin_o,
             serial_data_in_o}, 8'h0d);
        // port f outputs held still, as during a conversion
        pf_dir_i = 8'hff;
        pf_latch_i = 8'hff;
        jtag_enable_i = 1'b1;
        step(3);
        chk(pf_oe_o, 8'h0f);
        chk(pf_pullup_o, 8'hf0);
        chk(pf_out_o, 8'h0f);
        repeat (5) tck(1'b1, 1'b0);
        tck(1'b0, 1'b0);
        tck(1'b1, 1'b0);
        tck(1'b1, 1'b0);
        tck(1'b0, 1'b0);
        tck(1'b0, 1'b0);
        tck(1'b0, 1'b1);
        chk(pf_oe_o & 8'h40, 8'h40);
        tck(1'b0, 1'b0);
        tck(1'b0, 1'b1);
        tck(1'b1, 1'b0);
        tck(1'b1, 1'b0);
        tck(1'b0, 1'b0);
        step(4);
        chk({4'h0, tap_ir_o}, 8'h05);
        chk(pf_oe_o & 8'h40, 8'h00);
        // data scan through the 8-bit chain, lsb first
        scan_word = 8'ha5;
        tck(1'b1, 1'b0);
        tck(1'b0, 1'b0);
        tck(1'b0, 1'b0);
        for (int b = 0; b < 8; b++)
            tck(b == 7, scan_word[b]);
        tck(1'b1, 1'b0);
        tck(1'b0, 1'b0);
        step(4);
        chk(dr_update_o, 8'ha5);
        chk(pf_in_o, 8'h0f);
        summarize;
    end
endmodule // tb_top
`default_nettype wire
